// File: design/sam_consts.vh
`ifndef SAM_CONSTS_VH
`define SAM_CONSTS_VH
// ==========================================
// Register map (word index on the register port)
`define SAM_REG_CTRL     2'h0
`define SAM_REG_STATUS   2'h1
`define SAM_REG_VECADDR  2'h2
`define SAM_REG_OCTADDR  2'h3
// ==========================================
// Field positions
`define SAM_CTRL_EN      0
`define SAM_ST_CUE_ERR   0
`define SAM_ST_STORE     1
`define SAM_ST_FILL      2
`define SAM_ST_CNT_LO    3
`define SAM_ST_CNT_HI    6
// ==========================================
// Reset values
`define SAM_CTRL_RST     1'h1
// ==========================================
// Cue codes
`define SAM_CUE_X        2'h0
`define SAM_CUE_Y        2'h1
`define SAM_CUE_FILL     2'h2
// ==========================================
// Sizes and counts
`define SAM_CUE_DEPTH    4'h8
`define SAM_ADDR_STEP    25'h0000001
`endif

// File: design/sam_store_addr_req.v
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Vector start loads 25-bit result address from parameter transfer register.
// R2 - Self-loop step adds one to result address, up or down by sign.
// R3 - New self-loop adds inner step; new inner loop adds outer step.
// R4 - Scalar store address: 21-bit store pointer plus 4-bit stack level six element.
// R5 - Scalar address captured at pipe entry, moved out one clock before result.
// R6 - Result octet address loads one clock before writing; half copy follows.
// R7 - Half-phase octet copy lags; forwarded to store address on new octet.
// R8 - Store address load raises a memory store request at once.
// R9 - Sixteen halfword flags set when the pipe writes that halfword.
// R10 - Half-phase flag copy lags and gates operand file updates.
// R11 - Store flags load from half copy when octet moves to store buffer.
// R12 - Four-bit word steer address loads element address, reloads after use.
// R13 - Stores first; X/Y conflicts alternate, X first; winner to hold register.
// R14 - Hold register keeps address until the request is finished.
// R15 - Request address moves to memory stage only after previous acceptance.
// R16 - Any word with exactly one halfword flag set demands a fill-in.
// R17 - Zone bit per word is OR of its pair; loaded at hold entry.
// R18 - Zone bits move out with memory acceptance; memory writes zoned words.
// R19 - Each fetch pushes a 2-bit cue; returns routed by oldest cue.
// R20 - Store start: complete words store with zones, else fill-in.
// R21 - Fill-in fetches octet, merges unwritten halfwords, then stores.
// R22 - Cue file: eight 2-bit entries in order; 00 X, 01 Y, 10 fill.
// R23 - Cue code 11 discards the octet and flags an internal error.
`include "sam_consts.vh"

module sam_store_addr_req (
	input  wire        I_SYS_CLK,
	input  wire        I_RST,
	input  wire        I_VEC_START,
	input  wire [24:0] I_PARAM_ADDR,
	input  wire        I_STEP_SELF,
	input  wire        I_STEP_INNER,
	input  wire        I_STEP_OUTER,
	input  wire        I_STEP_NEG,
	input  wire [24:0] I_INNER_STEP,
	input  wire [24:0] I_OUTER_STEP,
	input  wire        I_SCALAR_CAPTURE,
	input  wire [20:0] I_STORE_POINTER,
	input  wire [3:0]  I_STACK_ELEM,
	input  wire        I_RESULT_PRELOAD,
	input  wire        I_RESULT_SCALAR,
	input  wire        I_FLUSH,
	input  wire        I_PIPE_WRITE,
	input  wire        I_PIPE_FULLWORD,
	input  wire        I_X_REQ,
	input  wire [20:0] I_X_ADDR,
	input  wire        I_Y_REQ,
	input  wire [20:0] I_Y_ADDR,
	input  wire        I_MEM_ACCEPT,
	input  wire        I_RET_VALID,
	input  wire [1:0]  I_REG_ADDR,
	input  wire [31:0] I_REG_WDATA,
	input  wire        I_REG_WR,
	input  wire        I_REG_RD,
	output reg  [31:0] O_REG_RDATA,
	output reg  [24:0] O_RESULT_VEC_ADDR,
	output reg  [20:0] O_OCTET_ADDR,
	output reg  [3:0]  O_WORD_STEER,
	output reg  [15:0] O_UPDATE_GATE,
	output reg  [15:0] O_STORE_FLAGS,
	output reg         O_STORE_BUSY,
	output reg         O_X_TAKEN,
	output reg         O_Y_TAKEN,
	output reg         O_MEM_REQ,
	output reg         O_MEM_WRITE,
	output reg  [20:0] O_MEM_ADDR,
	output reg  [7:0]  O_MEM_ZONE,
	output reg         O_ROUTE_X,
	output reg         O_ROUTE_Y,
	output reg         O_ROUTE_FILL,
	output reg         O_CUE_ERR
);

// ==========================================
// Helper functions
function [7:0] zone_of;
	input [15:0] f;
	integer k;
	begin
		for (k = 0; k < 8; k = k + 1) begin
			zone_of[k] = f[2*k] | f[2*k+1];
		end
	end
endfunction

function half_word;
	input [15:0] f;
	integer k;
	begin
		half_word = 1'b0;
		for (k = 0; k < 8; k = k + 1) begin
			half_word = half_word | (f[2*k] ^ f[2*k+1]);
		end
	end
endfunction

// ==========================================
// Address generation state
reg  [24:0] scalar_store_address;
reg  [20:0] half_phase_octet_address;
reg  [15:0] halfword_written_flags;
reg         octet_live;
reg         ctrl_en;
reg  [24:0] next_vec;
reg  [15:0] wr_mask;
wire [24:0] src_addr = I_RESULT_SCALAR ? scalar_store_address : O_RESULT_VEC_ADDR;
wire        new_octet = I_RESULT_PRELOAD & (~octet_live | (src_addr[24:4] != O_OCTET_ADDR));
wire        store_xfer = (new_octet & octet_live) | (I_FLUSH & octet_live);

always @* begin
	next_vec = O_RESULT_VEC_ADDR;
	// R2 unit step
	if (I_STEP_SELF) begin
		next_vec = I_STEP_NEG ? O_RESULT_VEC_ADDR - `SAM_ADDR_STEP : O_RESULT_VEC_ADDR + `SAM_ADDR_STEP;
	end
	// R3 loop steps
	if (I_STEP_INNER) begin
		next_vec = O_RESULT_VEC_ADDR + I_INNER_STEP;
	end
	if (I_STEP_OUTER) begin
		next_vec = O_RESULT_VEC_ADDR + I_OUTER_STEP;
	end
	// R1 vector start
	if (I_VEC_START) begin
		next_vec = I_PARAM_ADDR;
	end
	// R9 halfword detect
	wr_mask = 16'h0000;
	if (I_PIPE_WRITE) begin
		wr_mask[O_WORD_STEER] = 1'b1;
		if (I_PIPE_FULLWORD) begin
			wr_mask[O_WORD_STEER ^ 4'h1] = 1'b1;
		end
	end
end

always @(posedge I_SYS_CLK or posedge I_RST) begin
	if (I_RST) begin
		O_RESULT_VEC_ADDR        <= 25'h0000000;
		scalar_store_address     <= 25'h0000000;
		O_OCTET_ADDR             <= 21'h000000;
		half_phase_octet_address <= 21'h000000;
		O_WORD_STEER             <= 4'h0;
		halfword_written_flags   <= 16'h0000;
		O_UPDATE_GATE            <= 16'h0000;
		octet_live               <= 1'b0;
	end else begin
		O_RESULT_VEC_ADDR <= next_vec;
		// R4 R5 scalar capture at pipe entry
		if (I_SCALAR_CAPTURE) begin
			scalar_store_address <= {I_STORE_POINTER, I_STACK_ELEM};
		end
		// R6 R12 octet and word steer load
		if (I_RESULT_PRELOAD) begin
			O_OCTET_ADDR <= src_addr[24:4];
			O_WORD_STEER <= src_addr[3:0];
			octet_live   <= 1'b1;
		end else if (I_FLUSH) begin
			octet_live <= 1'b0;
		end
		// R7 R10 half-phase copies lag by one edge
		half_phase_octet_address <= O_OCTET_ADDR;
		O_UPDATE_GATE            <= halfword_written_flags;
		// R9 flags restart with each new octet
		if (store_xfer | new_octet) begin
			halfword_written_flags <= 16'h0000;
		end else begin
			halfword_written_flags <= halfword_written_flags | wr_mask;
		end
	end
end

// ==========================================
// Requester state
localparam ST_IDLE = 2'h0;
localparam ST_FILL = 2'h1;
localparam ST_DONE = 2'h2;

localparam K_X     = 2'h0;
localparam K_Y     = 2'h1;
localparam K_FILL  = 2'h2;
localparam K_STORE = 2'h3;

reg  [20:0] store_octet_address;
reg  [20:0] granted_octet_hold;
reg  [1:0]  hold_kind;
reg         hold_valid;
reg  [7:0]  word_zone_bits;
reg  [1:0]  fill_state;
reg         y_turn;
reg         cue_err;
reg  [1:0]  cue_mem [0:7];
reg  [2:0]  cue_wr;
reg  [2:0]  cue_rd;
reg  [3:0]  cue_cnt;
reg  [1:0]  cue_head;
reg  [1:0]  next_kind;
reg         grant;

wire        cue_room = (cue_cnt != `SAM_CUE_DEPTH);
// Hold is freed exactly when its address enters the memory stage
wire        hold_move = hold_valid & (~O_MEM_REQ | I_MEM_ACCEPT);
wire        hold_free = ~hold_valid | hold_move;
wire        ret_pop = I_RET_VALID & (cue_cnt != 4'h0);
wire        need_fill = half_word(O_STORE_FLAGS);
// A requester drops only after it sees taken, so that edge must not grant it again
wire        x_live = I_X_REQ & ~O_X_TAKEN;
wire        y_live = I_Y_REQ & ~O_Y_TAKEN;
wire        cue_push = grant & (next_kind != K_STORE);

always @* begin
	grant     = 1'b0;
	next_kind = K_X;
	cue_head  = cue_mem[cue_rd];
	if (ctrl_en & hold_free) begin
		// R13 stores win over fetches
		if (O_STORE_BUSY & (fill_state != ST_FILL)) begin
			grant = (fill_state == ST_DONE) | ~need_fill | cue_room;
			// R20 R16 octets with no half words store, half words fetch first
			next_kind = ((fill_state == ST_DONE) | ~need_fill) ? K_STORE : K_FILL;
		end else if (~O_STORE_BUSY & cue_room & (x_live | y_live)) begin
			grant = 1'b1;
			// R13 alternate on conflict
			next_kind = (y_live & (~x_live | y_turn)) ? K_Y : K_X;
		end
	end
end

always @(posedge I_SYS_CLK or posedge I_RST) begin
	if (I_RST) begin
		store_octet_address <= 21'h000000;
		O_STORE_FLAGS       <= 16'h0000;
		O_STORE_BUSY        <= 1'b0;
		granted_octet_hold  <= 21'h000000;
		hold_kind           <= K_X;
		hold_valid          <= 1'b0;
		word_zone_bits      <= 8'h00;
		fill_state          <= ST_IDLE;
		y_turn              <= 1'b0;
		O_X_TAKEN           <= 1'b0;
		O_Y_TAKEN           <= 1'b0;
		O_MEM_REQ           <= 1'b0;
		O_MEM_WRITE         <= 1'b0;
		O_MEM_ADDR          <= 21'h000000;
		O_MEM_ZONE          <= 8'h00;
		cue_wr              <= 3'h0;
		cue_rd              <= 3'h0;
		cue_cnt             <= 4'h0;
		O_ROUTE_X           <= 1'b0;
		O_ROUTE_Y           <= 1'b0;
		O_ROUTE_FILL        <= 1'b0;
		O_CUE_ERR           <= 1'b0;
	end else begin
		// Single store buffer: an octet sent while a store is pending is lost
		// R7 R8 R11 octet leaves for the store buffer, request raised
		if (store_xfer & ~O_STORE_BUSY) begin
			store_octet_address <= half_phase_octet_address;
			// Writes in the transfer cycle still belong to the leaving octet
			O_STORE_FLAGS       <= O_UPDATE_GATE | halfword_written_flags | wr_mask;
			O_STORE_BUSY        <= 1'b1;
			fill_state          <= ST_IDLE;
		end
		O_X_TAKEN <= grant & (next_kind == K_X);
		O_Y_TAKEN <= grant & (next_kind == K_Y);
		// R14 hold keeps the winner until it moves on
		if (grant) begin
			hold_valid         <= 1'b1;
			hold_kind          <= next_kind;
			granted_octet_hold <= (next_kind == K_X) ? I_X_ADDR :
			                      (next_kind == K_Y) ? I_Y_ADDR : store_octet_address;
			if (x_live & y_live & ~O_STORE_BUSY) begin
				y_turn <= ~y_turn;
			end
			// R17 zone bits load with store address
			if (next_kind == K_STORE) begin
				word_zone_bits <= zone_of(O_STORE_FLAGS);
				O_STORE_BUSY   <= 1'b0;
				fill_state     <= ST_IDLE;
			end
			// R21 fill-in fetch
			if (next_kind == K_FILL) begin
				fill_state <= ST_FILL;
			end
		end else if (hold_move) begin
			hold_valid <= 1'b0;
		end
		// R15 R18 memory stage takes new address and zones only after acceptance
		if (hold_move) begin
			O_MEM_REQ   <= 1'b1;
			O_MEM_ADDR  <= granted_octet_hold;
			O_MEM_WRITE <= (hold_kind == K_STORE);
			O_MEM_ZONE  <= (hold_kind == K_STORE) ? word_zone_bits : 8'h00;
		end else if (I_MEM_ACCEPT) begin
			O_MEM_REQ <= 1'b0;
		end
		// R19 R22 cue push per fetch, pop per return
		if (cue_push) begin
			cue_wr <= cue_wr + 3'h1;
		end
		if (ret_pop) begin
			cue_rd <= cue_rd + 3'h1;
		end
		cue_cnt <= cue_cnt + {3'h0, cue_push} - {3'h0, ret_pop};
		O_ROUTE_X    <= ret_pop & (cue_head == `SAM_CUE_X);
		O_ROUTE_Y    <= ret_pop & (cue_head == `SAM_CUE_Y);
		O_ROUTE_FILL <= ret_pop & (cue_head == `SAM_CUE_FILL);
		// R21 fill octet merged, store may go
		if (ret_pop & (cue_head == `SAM_CUE_FILL) & (fill_state == ST_FILL)) begin
			fill_state <= ST_DONE;
		end
		// R23 bad cue discarded and flagged
		O_CUE_ERR <= ret_pop & (cue_head == K_STORE);
	end
end

// ==========================================
// Cue storage
// No reset here: an entry is only read after it has been written
always @(posedge I_SYS_CLK) begin
	// R22 entry written in request order
	if (cue_push) begin
		cue_mem[cue_wr] <= next_kind;
	end
end

// ==========================================
// Register port
wire cue_err_clr = I_REG_WR & (I_REG_ADDR == `SAM_REG_STATUS) & I_REG_WDATA[`SAM_ST_CUE_ERR];

always @(posedge I_SYS_CLK or posedge I_RST) begin
	if (I_RST) begin
		ctrl_en     <= `SAM_CTRL_RST;
		cue_err     <= 1'b0;
		O_REG_RDATA <= 32'h00000000;
	end else begin
		if (I_REG_WR & (I_REG_ADDR == `SAM_REG_CTRL)) begin
			ctrl_en <= I_REG_WDATA[`SAM_CTRL_EN];
		end
		// Set wins over a clear in the same cycle
		if (ret_pop & (cue_head == K_STORE)) begin
			cue_err <= 1'b1;
		end else if (cue_err_clr) begin
			cue_err <= 1'b0;
		end
		O_REG_RDATA <= 32'h00000000;
		if (I_REG_RD) begin
			case (I_REG_ADDR)
				`SAM_REG_CTRL: begin
					O_REG_RDATA[`SAM_CTRL_EN] <= ctrl_en;
				end
				`SAM_REG_STATUS: begin
					O_REG_RDATA[`SAM_ST_CUE_ERR] <= cue_err;
					O_REG_RDATA[`SAM_ST_STORE]   <= O_STORE_BUSY;
					O_REG_RDATA[`SAM_ST_FILL]    <= (fill_state == ST_FILL);
					O_REG_RDATA[`SAM_ST_CNT_HI:`SAM_ST_CNT_LO] <= cue_cnt;
				end
				`SAM_REG_VECADDR: begin
					O_REG_RDATA[24:0] <= O_RESULT_VEC_ADDR;
				end
				`SAM_REG_OCTADDR: begin
					O_REG_RDATA[20:0] <= store_octet_address;
				end
				default: begin
					O_REG_RDATA <= 32'h00000000;
				end
			endcase
		end
	end
end

endmodule

// File: verif/sam_store_addr_req_props.sv
`timescale 1ns/1ns
// ==========================================
// Port checker
module sam_store_addr_req_props (
	input logic        I_SYS_CLK,
	input logic        I_RST,
	input logic        I_VEC_START,
	input logic [24:0] I_PARAM_ADDR,
	input logic        I_STEP_SELF,
	input logic        I_STEP_INNER,
	input logic        I_STEP_OUTER,
	input logic        I_STEP_NEG,
	input logic [24:0] I_OUTER_STEP,
	input logic        I_MEM_ACCEPT,
	input logic        I_RET_VALID,
	input logic [24:0] O_RESULT_VEC_ADDR,
	input logic        O_STORE_BUSY,
	input logic        O_X_TAKEN,
	input logic        O_Y_TAKEN,
	input logic        O_MEM_REQ,
	input logic        O_MEM_WRITE,
	input logic [20:0] O_MEM_ADDR,
	input logic [7:0]  O_MEM_ZONE,
	input logic        O_ROUTE_X,
	input logic        O_ROUTE_Y,
	input logic        O_ROUTE_FILL,
	input logic        O_CUE_ERR
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	wire [24:0] one = 25'h0000001;
	// ==========================================
	// Address generation
	AST_VEC_LOAD: assert property (I_VEC_START |=> O_RESULT_VEC_ADDR == $past(I_PARAM_ADDR))
		else $error("vector start load wrong");
	AST_SELF_STEP: assert property (I_STEP_SELF && !I_STEP_INNER && !I_STEP_OUTER && !I_VEC_START |=>
		O_RESULT_VEC_ADDR == ($past(I_STEP_NEG) ? $past(O_RESULT_VEC_ADDR) - one : $past(O_RESULT_VEC_ADDR) + one))
		else $error("self step wrong");
	AST_OUTER_STEP: assert property (I_STEP_OUTER && !I_VEC_START |=>
		O_RESULT_VEC_ADDR == $past(O_RESULT_VEC_ADDR) + $past(I_OUTER_STEP))
		else $error("outer step wrong");
	// ==========================================
	// Requester
	AST_STORE_REQ: assert property ($rose(O_STORE_BUSY) |-> ##[1:40] O_MEM_REQ)
		else $error("store never requested memory");
	AST_ONE_GRANT: assert property (!(O_X_TAKEN && O_Y_TAKEN))
		else $error("both fetches granted");
	AST_ADDR_HOLD: assert property (O_MEM_REQ && !I_MEM_ACCEPT |=> O_MEM_REQ && $stable(O_MEM_ADDR))
		else $error("request address moved before accept");
	AST_ZONE_HOLD: assert property (O_MEM_REQ && !I_MEM_ACCEPT |=> $stable(O_MEM_ZONE) && $stable(O_MEM_WRITE))
		else $error("zone moved before accept");
	AST_FETCH_ZONE: assert property (O_MEM_REQ && !O_MEM_WRITE |-> O_MEM_ZONE == 8'h00)
		else $error("fetch carries zone bits");
	AST_ROUTE_CAUSE: assert property (O_ROUTE_X || O_ROUTE_Y || O_ROUTE_FILL |-> $past(I_RET_VALID))
		else $error("route without return");
	AST_ROUTE_ONE: assert property ($onehot0({O_ROUTE_X, O_ROUTE_Y, O_ROUTE_FILL, O_CUE_ERR}))
		else $error("several routes at once");
	COV_STORE: cover property (O_MEM_REQ && O_MEM_WRITE && I_MEM_ACCEPT);
	COV_FILL: cover property (O_ROUTE_FILL);
	COV_Y: cover property (O_Y_TAKEN);
endmodule

bind sam_store_addr_req sam_store_addr_req_props chk_u (
	.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_VEC_START(I_VEC_START), .I_PARAM_ADDR(I_PARAM_ADDR),
	.I_STEP_SELF(I_STEP_SELF), .I_STEP_INNER(I_STEP_INNER), .I_STEP_OUTER(I_STEP_OUTER),
	.I_STEP_NEG(I_STEP_NEG), .I_OUTER_STEP(I_OUTER_STEP), .I_MEM_ACCEPT(I_MEM_ACCEPT),
	.I_RET_VALID(I_RET_VALID), .O_RESULT_VEC_ADDR(O_RESULT_VEC_ADDR), .O_STORE_BUSY(O_STORE_BUSY),
	.O_X_TAKEN(O_X_TAKEN), .O_Y_TAKEN(O_Y_TAKEN), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WRITE(O_MEM_WRITE),
	.O_MEM_ADDR(O_MEM_ADDR), .O_MEM_ZONE(O_MEM_ZONE), .O_ROUTE_X(O_ROUTE_X), .O_ROUTE_Y(O_ROUTE_Y),
	.O_ROUTE_FILL(O_ROUTE_FILL), .O_CUE_ERR(O_CUE_ERR)
);

// File: verif/sam_mem_model.sv
`timescale 1ns/1ns
// ==========================================
// Memory side: accepts one address at a time, answers fetches in order
module sam_mem_model (
	input  wire  i_clk,
	input  wire  i_rst,
	input  wire  i_req,
	input  wire  i_write,
	input  wire  i_slow,
	output logic o_accept,
	output wire  o_ret
);
	logic [1:0] wait_cnt;
	logic [2:0] ret_pipe;
	assign o_ret = ret_pipe[2];
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wait_cnt <= 2'h0;
			o_accept <= 1'b0;
			ret_pipe <= 3'h0;
		end else begin
			o_accept <= 1'b0;
			ret_pipe <= {ret_pipe[1:0], o_accept && !i_write};
			// next address only after the last one was taken
			if (i_req && !o_accept) begin
				if (!i_slow || wait_cnt == 2'h2) begin
					o_accept <= 1'b1;
					wait_cnt <= 2'h0;
				end else begin
					wait_cnt <= wait_cnt + 2'h1;
				end
			end
		end
	end
endmodule

// File: verif/sam_store_addr_req_tb.sv
`timescale 1ns/1ns
module sam_store_addr_req_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  ctl = 8'h00;
	logic        fw = 1'b0, rs = 1'b0, neg = 1'b0, rr = 1'b0, rw = 1'b0, slow = 1'b0;
	logic        xr, yr, go = 1'b0, xgot = 1'b0, ygot = 1'b0, cerr;
	logic [1:0]  ra = 2'h0, ord = 2'h3;
	logic [31:0] rdata, wd = 32'h0;
	logic [24:0] pa = 25'h0, inner = 25'h0, outer = 25'h0, vaddr;
	logic [20:0] ptr = 21'h0, xa = 21'h0, ya = 21'h0, oct, maddr;
	logic [3:0]  elem = 4'h0, steer;
	logic [15:0] sflags, gate;
	logic [7:0]  zone;
	logic        xt, yt, mreq, mwr, acc, ret, rx, ry, rf, busy;
	int          err_total = 0, tests_run = 0, nx = 0, ny = 0, nf = 0, ne = 0;
	always #25 clk = ~clk;
	sam_store_addr_req dut_u (.I_SYS_CLK(clk), .I_RST(rst), .I_VEC_START(ctl[0]), .I_PARAM_ADDR(pa),
		.I_STEP_SELF(ctl[1]), .I_STEP_INNER(ctl[2]), .I_STEP_OUTER(ctl[3]), .I_STEP_NEG(neg),
		.I_INNER_STEP(inner), .I_OUTER_STEP(outer), .I_SCALAR_CAPTURE(ctl[4]), .I_STORE_POINTER(ptr),
		.I_STACK_ELEM(elem), .I_RESULT_PRELOAD(ctl[5]), .I_RESULT_SCALAR(rs), .I_FLUSH(ctl[6]),
		.I_PIPE_WRITE(ctl[7]), .I_PIPE_FULLWORD(fw), .I_X_REQ(xr), .I_X_ADDR(xa), .I_Y_REQ(yr),
		.I_Y_ADDR(ya), .I_MEM_ACCEPT(acc), .I_RET_VALID(ret), .I_REG_ADDR(ra), .I_REG_WDATA(wd),
		.I_REG_WR(rw), .I_REG_RD(rr), .O_REG_RDATA(rdata), .O_RESULT_VEC_ADDR(vaddr), .O_OCTET_ADDR(oct),
		.O_WORD_STEER(steer), .O_UPDATE_GATE(gate), .O_STORE_FLAGS(sflags), .O_STORE_BUSY(busy),
		.O_X_TAKEN(xt), .O_Y_TAKEN(yt), .O_MEM_REQ(mreq), .O_MEM_WRITE(mwr), .O_MEM_ADDR(maddr),
		.O_MEM_ZONE(zone), .O_ROUTE_X(rx), .O_ROUTE_Y(ry), .O_ROUTE_FILL(rf), .O_CUE_ERR(cerr));
	sam_mem_model mem_u (.i_clk(clk), .i_rst(rst), .i_req(mreq), .i_write(mwr), .i_slow(slow),
		.o_accept(acc), .o_ret(ret));
	// ==========================================
	// Fetch requesters drop once granted; grant order logged
	assign xr = go && !xgot;
	assign yr = go && !ygot;
	always @(posedge clk) begin
		if (xt) begin
			xgot <= 1'b1;
			ord <= {ord[0], 1'b0};
		end
		if (yt) begin
			ygot <= 1'b1;
			ord <= {ord[0], 1'b1};
		end
		nx += rx;
		ny += ry;
		nf += rf;
		ne += cerr;
	end
	// ==========================================
	// Tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task rd(input logic [1:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		rw <= 1'b1;
		@(posedge clk);
		rw <= 1'b0;
	endtask
	// Bits of ctl: start, self, inner, outer, capture, preload, flush, pipe write
	task pulse(input int k);
		@(posedge clk);
		ctl <= 8'h01 << k;
		@(posedge clk);
		ctl <= 8'h00;
		#1;
	endtask
	// Bounded waits: a stuck requester ends as a mismatch in wreq, while settle just moves on
	task wreq(input logic w);
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			if (mreq && mwr === w) break;
		end
		chk(mreq, 1'b1);
	endtask
	task settle;
		int n;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			if (!mreq && !busy) break;
		end
		repeat (8) @(posedge clk);
	endtask
	task summarize;
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================
	// Watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		#100000;
		err_total++;
		summarize();
	end
	// ==========================================
	// Tests
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(2'h0, 32'h1);
		wr(2'h0, 32'h0);
		xa <= 21'h00100;
		ya <= 21'h00200;
		go <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk(mreq, 1'b0);
		wr(2'h0, 32'h1);
		wreq(1'b0);
		chk(maddr, 21'h00100);
		settle();
		chk(ord, 2'h1);
		chk(nx, 1);
		chk(ny, 1);
		pa <= 25'h0000032;
		inner <= 25'h0000010;
		outer <= 25'h1fffff0;
		pulse(0);
		chk(vaddr, 32'h32);
		rd(2'h2, 32'h32);
		pulse(1);
		chk(vaddr, 32'h33);
		neg <= 1'b1;
		pulse(1);
		chk(vaddr, 32'h32);
		neg <= 1'b0;
		pulse(2);
		chk(vaddr, 32'h42);
		pulse(3);
		chk(vaddr, 32'h32);
		pulse(5);
		chk(oct, 21'h3);
		chk(steer, 4'h2);
		fw <= 1'b1;
		pulse(7);
		fw <= 1'b0;
		chk(gate, 16'h0000);
		@(posedge clk);
		#1 chk(gate, 16'h000c);
		ptr <= 21'h00abc;
		elem <= 4'h7;
		slow <= 1'b1;
		pulse(4);
		rs <= 1'b1;
		pulse(5);
		rs <= 1'b0;
		wreq(1'b1);
		chk(maddr, 21'h3);
		chk(zone, 8'h02);
		chk(sflags, 16'h000c);
		chk(oct, 21'h00abc);
		chk(steer, 4'h7);
		settle();
		pulse(7);
		pulse(6);
		wreq(1'b0);
		chk(maddr, 21'h00abc);
		wreq(1'b1);
		chk(maddr, 21'h00abc);
		chk(zone, 8'h08);
		chk(nf, 1);
		settle();
		chk(ne, 0);
		rd(2'h1, 32'h0);
		summarize();
	end
endmodule
